// ===== core/pdc_phase_cfg.sv
// Purpose: coarse phase detector configuration register and phase result selection
// Assumes: phase samples come from detector logic on pclk; apb master on pclk
// Notes: one wait-free access phase; every output is registered
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
module pdc_phase_cfg
	import pdc_pkg::*;
#(
	parameter int UI_W = 16,
	parameter int FRAC_W = 12
) (
	input wire logic pclk, // apb and core clock
	input wire logic presetn, // asynchronous reset, active low
	input wire logic ce, // clock enable, freezes all state when low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high for write
	input wire logic [pdc_pkg::PDC_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [pdc_pkg::PDC_DATA_W-1:0] pwdata, // apb write data
	output logic [pdc_pkg::PDC_DATA_W-1:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic ph_valid, // phase sample strobe from detector
	input wire logic signed [UI_W-1:0] ph_ui, // whole input cycles of phase error
	input wire logic [FRAC_W-1:0] ph_frac, // fraction of one input cycle
	output logic pll_valid, // phase result strobe to main_output_pll
	output logic signed [UI_W+FRAC_W-1:0] pll_phase, // phase result to main_output_pll
	output logic coarse_loss, // sampled phase beyond coarse limit
	output logic wide_active // wide-range tracker running
);
	import pdc_pkg::*;

	localparam int PW = UI_W + FRAC_W;
	localparam logic signed [PW-1:0] ONE_CYC = PW'(1) << FRAC_W;

	// span in whole cycles for a limit code: 1, 3, 7 ... doubling plus one
	function automatic logic [UI_W-1:0] lim_span(input logic [PDC_LIM_W-1:0] code);
		logic [PDC_LIM_W-1:0] c;
		c = (code > PDC_LIM_MAX_CODE) ? PDC_LIM_MAX_CODE : code;
		return (UI_W'(1) << (c + 4'h1)) - UI_W'(1);
	endfunction

	function automatic logic signed [UI_W-1:0] clamp_ui(input logic signed [UI_W-1:0] v,
		input logic [UI_W-1:0] lim);
		logic signed [UI_W-1:0] l;
		l = $signed(lim);
		if (v > l) begin
			return l;
		end else if (v < -l) begin
			return -l;
		end
		return v;
	endfunction

	// register file
	pdc_apb_t apb_state, next_apb_state;
	logic [PDC_CFG_W-1:0] cfg, next_cfg;
	logic [PDC_DATA_W-1:0] next_prdata;
	logic next_pready, next_pslverr;
	logic cfg_hit, stat_hit, wr_done;
	logic [PDC_DATA_W-1:0] stat_word;

	// tracker and result
	logic signed [UI_W-1:0] trk_ui, next_trk_ui;
	logic next_coarse_loss;
	logic next_pll_valid;
	logic signed [PW-1:0] next_pll_phase;
	logic [UI_W-1:0] lim;
	logic wide_en, loss_en, use_multi;
	logic signed [UI_W-1:0] abs_ui;
	logic signed [PW-1:0] full_ph;

	assign wide_en = cfg[PDC_BIT_WIDE_EN];
	assign loss_en = cfg[PDC_BIT_LOSS_EN];
	assign lim = lim_span(cfg[PDC_LIM_MSB:PDC_LIM_LSB]);
	// the coarse result only exists while the wide tracker runs
	assign use_multi = cfg[PDC_BIT_MULTI] && wide_en;
	assign abs_ui = (ph_ui < 0) ? -ph_ui : ph_ui;

	always_comb begin
		cfg_hit = 1'b0;
		stat_hit = 1'b0;
		if (paddr == PDC_CFG_OFFSET) begin
			cfg_hit = 1'b1;
		end else if (paddr == PDC_STAT_OFFSET) begin
			stat_hit = 1'b1;
		end
	end

	always_comb begin
		stat_word = '0;
		stat_word[PDC_STAT_BIT_LOSS] = coarse_loss;
		stat_word[PDC_STAT_BIT_WIDE] = wide_active;
		stat_word[PDC_STAT_BIT_MULTI] = use_multi;
		stat_word[PDC_STAT_TRK_LSB +: UI_W] = trk_ui;
	end

	assign wr_done = (apb_state == PDC_ACCESS) && psel && penable && pready && pwrite
		&& cfg_hit;

	// read data and error are latched at setup so pready can come from a flop
	always_comb begin
		next_apb_state = apb_state;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		next_cfg = cfg;
		case (apb_state)
			PDC_IDLE: begin
				if (psel && !penable) begin
					next_apb_state = PDC_ACCESS;
					next_pready = 1'b1;
					next_pslverr = !(cfg_hit || stat_hit);
					if (!pwrite && cfg_hit) begin
						next_prdata = {{(PDC_DATA_W-PDC_CFG_W){1'b0}}, cfg};
					end else if (!pwrite && stat_hit) begin
						next_prdata = stat_word;
					end else begin
						next_prdata = '0;
					end
				end
			end
			PDC_ACCESS: begin
				next_apb_state = PDC_IDLE;
				if (wr_done) begin
					// unused bit 4 stays zero
					next_cfg = pwdata[PDC_CFG_W-1:0] & PDC_CFG_WMASK;
				end
			end
			default: begin
				next_apb_state = PDC_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_state <= PDC_IDLE;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
			cfg <= PDC_CFG_RESET;
		end else if (ce) begin
			apb_state <= next_apb_state;
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
			cfg <= next_cfg;
		end
	end

	// tracker: keeps the multi-cycle phase even when the PLL sees only one cycle
	always_comb begin
		next_trk_ui = trk_ui;
		next_coarse_loss = coarse_loss;
		next_pll_valid = 1'b0;
		next_pll_phase = pll_phase;
		full_ph = '0;
		if (!wide_en) begin
			next_trk_ui = '0;
			next_coarse_loss = 1'b0;
		end else if (ph_valid) begin
			next_trk_ui = clamp_ui(ph_ui, lim);
			next_coarse_loss = loss_en && (abs_ui > $signed(lim));
		end
		if (ph_valid) begin
			next_pll_valid = 1'b1;
			if (wide_en) begin
				full_ph = {next_trk_ui, ph_frac};
			end else begin
				full_ph = {ph_ui, ph_frac};
			end
			if (use_multi) begin
				next_pll_phase = full_ph;
			end else if (full_ph > ONE_CYC) begin
				next_pll_phase = ONE_CYC;
			end else if (full_ph < -ONE_CYC) begin
				next_pll_phase = -ONE_CYC;
			end else begin
				next_pll_phase = full_ph;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trk_ui <= '0;
			coarse_loss <= 1'b0;
			pll_valid <= 1'b0;
			pll_phase <= '0;
			wide_active <= 1'b0;
		end else if (ce) begin
			trk_ui <= next_trk_ui;
			coarse_loss <= next_coarse_loss;
			pll_valid <= next_pll_valid;
			pll_phase <= next_pll_phase;
			wide_active <= wide_en;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable && ce && apb_state == PDC_IDLE;
	endsequence

	sequence s_write_cfg;
		ce && psel && penable && pready && pwrite && cfg_hit;
	endsequence

	sequence s_sample;
		ce && ph_valid;
	endsequence

	// apb: answered in the first access cycle, never stretched
	a_apb_one_wait: assert property (s_setup
		|=> pready)
		else $error("pready not raised one cycle after setup");

	a_ready_pulse: assert property (ce && pready
		|=> !pready)
		else $error("pready held longer than one cycle");

	a_ready_idle: assert property (ce && apb_state == PDC_IDLE && !(psel && !penable)
		|=> !pready)
		else $error("pready without a setup cycle");

	a_unmapped_err: assert property (s_setup ##0 !(cfg_hit || stat_hit)
		|=> pslverr && prdata == '0)
		else $error("unmapped access not refused");

	a_unmapped_nowr: assert property (ce && psel && penable && pready && pwrite && !cfg_hit
		|=> $stable(cfg))
		else $error("write outside the config register changed it");

	a_cfg_read: assert property (s_setup ##0 (!pwrite && cfg_hit)
		|=> prdata == PDC_DATA_W'($past(cfg)))
		else $error("config read data wrong");

	a_cfg_write: assert property (s_write_cfg
		|=> cfg == ($past(pwdata[PDC_CFG_W-1:0]) & PDC_CFG_WMASK))
		else $error("config write not stored");

	a_stat_read: assert property (s_setup ##0 (!pwrite && stat_hit)
		|=> prdata[PDC_STAT_BIT_WIDE] == $past(wide_active))
		else $error("status read shows wrong wide state");

	// clock enable low must hold every piece of state, the bus included
	a_ce_freeze: assert property (!ce
		|=> $stable(cfg) && $stable(trk_ui) && $stable(pll_phase) && $stable(pready))
		else $error("state moved while clock enable low");

	a_wide_follow: assert property (ce
		|=> wide_active == $past(wide_en))
		else $error("wide active does not follow config");

	a_wide_off_idle: assert property (ce && !wide_en
		|=> trk_ui == 0 && !coarse_loss)
		else $error("tracker running with wide range off");

	a_track_bound: assert property (ce && wide_en && ph_valid
		|=> trk_ui <= $signed($past(lim)) && trk_ui >= -$signed($past(lim)))
		else $error("tracked phase beyond coarse span");

	a_loss_flag: assert property (ce && wide_en && loss_en && ph_valid && abs_ui > $signed(lim)
		|=> coarse_loss)
		else $error("coarse loss not flagged");

	a_loss_clear: assert property (s_sample ##0 (wide_en && !(loss_en && abs_ui > $signed(lim)))
		|=> !coarse_loss)
		else $error("coarse loss flagged inside span");

	a_loss_hold: assert property (ce && wide_en && !ph_valid
		|=> $stable(coarse_loss) && $stable(trk_ui))
		else $error("tracker moved without a sample");

	a_single_clamp: assert property (ce && ph_valid && !use_multi
		|=> pll_valid && pll_phase <= ONE_CYC && pll_phase >= -ONE_CYC)
		else $error("single cycle result exceeds one cycle");

	a_small_pass: assert property (s_sample ##0 (!wide_en && ph_ui == 0)
		|=> pll_phase == PW'($past(ph_frac)))
		else $error("in-range phase not passed unchanged");

	// multi bit alone must not open the coarse result to the pll
	a_multi_gate: assert property (s_sample ##0 (cfg[PDC_BIT_MULTI] && !wide_en)
		|=> pll_phase <= ONE_CYC && pll_phase >= -ONE_CYC)
		else $error("multi cycle result used with wide range off");

	a_multi_pass: assert property (s_sample ##0 use_multi
		|=> pll_valid && pll_phase == {trk_ui, $past(ph_frac)})
		else $error("multi cycle result not passed to pll");

	a_phase_hold: assert property (ce && !ph_valid
		|=> $stable(pll_phase))
		else $error("phase result moved without a sample");

	a_valid_pulse: assert property (ce && !ph_valid
		|=> !pll_valid)
		else $error("phase strobe without sample");
endmodule

// ===== core/pdc_pkg.sv
// Purpose: shared constants for the wide-range phase detector configuration slice
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: field positions refer to the 8-bit coarse configuration register, status positions to the 32-bit status word
package pdc_pkg;
	localparam int PDC_ADDR_W = 12;
	localparam int PDC_DATA_W = 32;
	localparam int PDC_CFG_W = 8;

	localparam logic [PDC_ADDR_W-1:0] PDC_CFG_OFFSET = 12'h074;
	localparam logic [PDC_ADDR_W-1:0] PDC_STAT_OFFSET = 12'h078;

	localparam logic [PDC_CFG_W-1:0] PDC_CFG_RESET = 8'h85;
	localparam logic [PDC_CFG_W-1:0] PDC_CFG_WMASK = 8'hEF;

	localparam int PDC_BIT_LOSS_EN = 7;
	localparam int PDC_BIT_WIDE_EN = 6;
	localparam int PDC_BIT_MULTI = 5;
	localparam int PDC_LIM_MSB = 3;
	localparam int PDC_LIM_LSB = 0;
	localparam int PDC_LIM_W = 4;

	// largest limit code that widens the tracking span; higher codes saturate
	localparam logic [PDC_LIM_W-1:0] PDC_LIM_MAX_CODE = 4'hB;

	localparam int PDC_STAT_BIT_LOSS = 0;
	localparam int PDC_STAT_BIT_WIDE = 1;
	localparam int PDC_STAT_BIT_MULTI = 2;
	localparam int PDC_STAT_TRK_LSB = 16;

	typedef enum logic {
		PDC_IDLE = 1'b0,
		PDC_ACCESS = 1'b1
	} pdc_apb_t;
endpackage

// ===== verification/tb_pdc_phase_cfg.sv
// Purpose: self-checking bench for the coarse phase detector configuration slice
// Assumes: zero-wait apb slave; phase result one cycle after each sample
// Notes: expectations come from the bit layout and the limit code table
`timescale 1ns/100ps
module tb_pdc_phase_cfg;
	import pdc_pkg::*;
	logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, ph_valid = 0;
	logic [PDC_ADDR_W-1:0] paddr = '0;
	logic [PDC_DATA_W-1:0] pwdata = '0, prdata, rd;
	logic pready, pslverr, pll_valid, coarse_loss, wide_active, err;
	logic signed [15:0] ph_ui = '0;
	logic [11:0] ph_frac = '0;
	logic signed [27:0] pll_phase;
	int n_fail = 0, check_count = 0;
	pdc_phase_cfg u_pdc_phase_cfg (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ph_valid(ph_valid), .ph_ui(ph_ui),
		.ph_frac(ph_frac), .pll_valid(pll_valid), .pll_phase(pll_phase),
		.coarse_loss(coarse_loss), .wide_active(wide_active));
	initial forever #2 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	// the watchdog bounds the wait for pready
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// pready only moves on rising edges, so the falling edge shows what the next one samples
		@(negedge pclk);
		while (pready !== 1'b1) @(negedge pclk);
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 0;
		penable <= 0;
	endtask
	task automatic phase(input logic signed [15:0] u, input logic [11:0] f,
		input logic signed [27:0] e, input logic loss);
		@(posedge pclk);
		ph_valid <= 1;
		ph_ui <= u;
		ph_frac <= f;
		@(posedge pclk);
		ph_valid <= 0;
		#1;
		chk(32'(pll_valid), 32'h1);
		chk(32'(pll_phase), 32'(e));
		chk(32'(coarse_loss), 32'(loss));
	endtask
	task automatic t_regs;
		apb(0, PDC_CFG_OFFSET, 0);
		chk(rd, 32'h85);
		chk(32'(wide_active), 32'h0);
		apb(1, PDC_CFG_OFFSET, 32'hFF);
		apb(0, PDC_CFG_OFFSET, 0);
		chk(rd, 32'hEF);
		apb(0, 12'h07C, 0);
		chk({err, rd[30:0]}, 32'h80000000);
	endtask
	task automatic t_multi;
		apb(1, PDC_CFG_OFFSET, 32'hE3);
		@(posedge pclk);
		#1;
		chk(32'(wide_active), 32'h1);
		phase(20, 12'h123, 15 * 4096 + 12'h123, 1);
		phase(-20, 12'h005, -15 * 4096 + 5, 1);
		phase(-3, 12'h007, -3 * 4096 + 7, 0);
		apb(0, PDC_STAT_OFFSET, 0);
		chk(rd, 32'hFFFD0006);
		apb(1, PDC_CFG_OFFSET, 32'hEF);
		phase(5000, 12'h000, 4095 * 4096, 1);
		apb(1, PDC_CFG_OFFSET, 32'hE0);
		phase(2, 12'h000, 4096, 1);
	endtask
	task automatic t_clamp;
		apb(1, PDC_CFG_OFFSET, 32'hC3);
		phase(2, 12'h005, 4096, 0);
		phase(-2, 12'h005, -4096, 0);
		phase(0, 12'h009, 9, 0);
		phase(20, 12'h000, 4096, 1);
		apb(1, PDC_CFG_OFFSET, 32'h03);
		phase(20, 12'h000, 4096, 0);
		chk(32'(wide_active), 32'h0);
		apb(1, PDC_CFG_OFFSET, 32'h23);
		phase(20, 12'h000, 4096, 0);
	endtask
	task automatic t_freeze;
		@(posedge pclk);
		ce <= 0;
		ph_valid <= 1;
		ph_ui <= 0;
		ph_frac <= 12'h00A;
		@(posedge pclk);
		ce <= 1;
		ph_valid <= 0;
		#1;
		chk(32'(pll_valid), 32'h0);
		chk(32'(pll_phase), 32'h1000);
	endtask
	task automatic t_reset;
		@(posedge pclk);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		#1;
		chk(32'(pll_phase), 32'h0);
		chk(32'(wide_active), 32'h0);
		@(posedge pclk);
		presetn <= 1;
		apb(0, PDC_CFG_OFFSET, 0);
		chk(rd, 32'(PDC_CFG_RESET));
	endtask
	task automatic give_verdict;
		if (n_fail == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		t_regs();
		t_multi();
		t_clamp();
		t_freeze();
		t_reset();
		give_verdict();
	end
	initial begin
		repeat (5000) @(posedge pclk);
		n_fail++;
		give_verdict();
	end
endmodule
